// [hdl/cscm_defs.svh]
`ifndef CSCM_DEFS_SVH
`define CSCM_DEFS_SVH

// Mode control bit positions
`define CSCM_MODE_OP_BIT      0
`define CSCM_MODE_MIXED_BIT   1
`define CSCM_MODE_ALB_BIT     2
`define CSCM_MODE_DLB_BIT     3
`define CSCM_MODE_CNT_LO      4
`define CSCM_MODE_CNT_HI      6
`define CSCM_MODE_SWRST_BIT   7

// Clock divider bit positions
`define CSCM_CLK_SCD_LO       2
`define CSCM_CLK_SCD_HI       3
`define CSCM_CLK_MCD_LO       4
`define CSCM_CLK_MCD_HI       6
`define CSCM_CLK_ECHO_BIT     7

// Power bit positions
`define CSCM_PWR_GLOBAL_BIT   0
`define CSCM_PWR_ADC_BIT      3
`define CSCM_PWR_DAC_BIT      4
`define CSCM_PWR_REF_BIT      5
`define CSCM_PWR_REFOUT_BIT   6
`define CSCM_PWR_HISUP_BIT    7

// Gain bit positions
`define CSCM_GAIN_IN_LO       0
`define CSCM_GAIN_IN_HI       2
`define CSCM_GAIN_MODRST_BIT  3
`define CSCM_GAIN_OUT_LO      4
`define CSCM_GAIN_OUT_HI      6
`define CSCM_GAIN_MUTE_BIT    7

// DAC timing bit positions
`define CSCM_DTM_ADV_LO       0
`define CSCM_DTM_ADV_HI       4
`define CSCM_DTM_BYP_BIT      5

// Register addresses
`define CSCM_ADDR_MODE        3'h0
`define CSCM_ADDR_CLKDIV      3'h1
`define CSCM_ADDR_POWER       3'h2
`define CSCM_ADDR_GAIN        3'h3
`define CSCM_ADDR_DACTIME     3'h4

// Reset values
`define CSCM_REG_RESET        8'h00
`define CSCM_DEV_ZERO         3'h0
`define CSCM_DEV_ONE          3'h1

// Timing, in master clock cycles
`define CSCM_RST_CYCLES       3'h4
`define CSCM_SLOW_RELOAD      11'h7ff
`define CSCM_FAST_RELOAD      11'h0ff
`define CSCM_WORD_BITS        5'h10
`define CSCM_CNT_LAST         5'h01
`define CSCM_CNT_IDLE         5'h00

`endif

// [hdl/cscm_pkg.sv]
package cscm_pkg;

   typedef struct packed {
      logic [7:0] dac_timing_control;
      logic [7:0] gain_control;
      logic [7:0] power_control;
      logic [7:0] clock_divider_control;
      logic [7:0] mode_control;
   } cscm_regs_t;

   typedef struct packed {
      logic       ctl_flag;
      logic       rd_flag;
      logic [2:0] dev_addr;
      logic [2:0] reg_addr;
      logic [7:0] reg_data;
   } cscm_word_t;

   typedef enum logic [1:0] {
      CSCM_ST_RESET,
      CSCM_ST_PROGRAM,
      CSCM_ST_DATA,
      CSCM_ST_MIXED
   } cscm_state_t;

endpackage

// [hdl/cscm_rx.sv]
`timescale 1ns/100ps
`include "cscm_defs.svh"

module cscm_rx (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        serial_in,
   input  wire logic        in_frame_sync,
   output cscm_pkg::cscm_word_t word,
   output logic             word_valid
);

   logic [15:0] sh_r;
   logic [4:0]  cnt_r;
   logic [15:0] sh_nxt;

   assign sh_nxt = {sh_r[14:0], serial_in};

   // Sync high one cycle before the first bit, or on the last bit of a burst
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_r <= `CSCM_CNT_IDLE;
      end else if (in_frame_sync) begin
         cnt_r <= `CSCM_WORD_BITS;
      end else if (cnt_r != `CSCM_CNT_IDLE) begin
         cnt_r <= cnt_r - `CSCM_CNT_LAST;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sh_r <= 16'h0000;
      end else if (cnt_r != `CSCM_CNT_IDLE) begin
         sh_r <= sh_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         word       <= '0;
         word_valid <= 1'b0;
      end else begin
         word_valid <= (cnt_r == `CSCM_CNT_LAST);
         if (cnt_r == `CSCM_CNT_LAST) begin
            word <= sh_nxt;
         end
      end
   end

endmodule

// [hdl/cscm_buf2.sv]
`timescale 1ns/100ps

module cscm_buf2 (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        in_valid,
   output logic             in_ready,
   input  cscm_pkg::cscm_word_t in_data,
   output logic             out_valid,
   input  wire logic        out_ready,
   output cscm_pkg::cscm_word_t out_data
);

   cscm_pkg::cscm_word_t mem_r [2];
   logic                 wp_r;
   logic                 rp_r;
   logic [1:0]           cnt_r;
   logic                 push;
   logic                 pop;

   assign in_ready  = (cnt_r != 2'h2);
   assign out_valid = (cnt_r != 2'h0);
   assign out_data  = mem_r[rp_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wp_r] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wp_r  <= 1'b0;
         rp_r  <= 1'b0;
         cnt_r <= 2'h0;
      end else begin
         if (push) begin
            wp_r <= ~wp_r;
         end
         if (pop) begin
            rp_r <= ~rp_r;
         end
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

// [hdl/cscm_top.sv]
`timescale 1ns/100ps
`include "cscm_defs.svh"

// Function
// - Mode register bit 0: 0 program mode, 1 data mode.
// - Mode bit 1 enables mixed mode; bits 2,3 (analog, digital loop-back) are stored but drive nothing.
// - Mode bits 6:4 hold cascade device count, bit 4 least significant.
// - Writing 1 to mode bit 7 starts software reset; 0 does nothing.
// - Clock divider: bits 3:2 serial, 6:4 master divider, bit 7 echo.
// - Power: global, ADC, DAC, reference, reference output, high supply.
// - Gain: input gain, modulator reset, output gain, mute.
// - DAC timing: bits 4:0 load advance, bit 5 interpolator bypass.
// - In program mode frames with the control flag set are control words; others are dropped.
// - Address zero accepted; otherwise decremented and forwarded out.
// - Once serial enable rises after reset, output frame sync is raised.
// - Output frames every 2048 clocks until divider written, then 256.
// - Program mode output words carry the ADC sample when no forward is pending.
// - Data mode without mixed: every frame is DAC data.
// - Data mode counts frames; frame matching device count loads DAC.
// - Plain data mode ignores control changes until hardware reset.
// - Mixed mode frame with MSB 0: 15 bits to DAC, LSB zero.
// - Mixed mode forces MSB of each ADC output word to zero.
// - Mixed mode may be entered by the very first control word.
// - Control word: flag, read, device address, register address, data.
// - Any reset clears registers, lasts 4 clocks, leaves program mode.
// - Read word returns register contents in the outgoing data field.
module cscm_top (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic               serial_port_enable,
   input  wire logic               serial_in,
   input  wire logic               in_frame_sync,
   input  wire logic [15:0]        adc_sample,
   output logic                    serial_out,
   output logic                    out_frame_sync,
   output cscm_pkg::cscm_regs_t    ctrl_regs,
   output cscm_pkg::cscm_state_t   op_state,
   output logic                    in_reset,
   output logic [15:0]             dac_data,
   output logic                    dac_load,
   output logic                    rx_overrun
);

   cscm_pkg::cscm_regs_t  regs_r;
   cscm_pkg::cscm_state_t st_r;
   cscm_pkg::cscm_state_t st_nxt;
   cscm_pkg::cscm_word_t  rx_word;
   cscm_pkg::cscm_word_t  head;
   cscm_pkg::cscm_word_t  fwd_r;
   logic                  rx_valid;
   logic                  rx_ready;
   logic                  head_valid;
   logic                  head_take;
   logic [2:0]            rst_cnt_r;
   logic                  busy;
   logic                  fwd_v_r;
   logic                  fast_r;
   logic [10:0]           tmr_r;
   logic                  sample_evt;
   logic [15:0]           tx_sh_r;
   logic [4:0]            tx_cnt_r;
   logic [2:0]            frm_cnt_r;
   logic                  is_ctl;
   logic                  is_dac;
   logic                  mine;
   logic                  ctl_wr;
   logic                  ctl_rd;
   logic                  swrst_req;
   logic                  echo;
   logic [15:0]           dac_word;
   logic [15:0]           tx_word;

   function automatic logic [7:0] reg_read(input cscm_pkg::cscm_regs_t r,
                                           input logic [2:0] a);
      logic [7:0] v;
      v = 8'h00;
      case (a)
         `CSCM_ADDR_MODE:    v = r.mode_control;
         `CSCM_ADDR_CLKDIV:  v = r.clock_divider_control;
         `CSCM_ADDR_POWER:   v = r.power_control;
         `CSCM_ADDR_GAIN:    v = r.gain_control;
         `CSCM_ADDR_DACTIME: v = r.dac_timing_control;
         default:            v = 8'h00;
      endcase
      return v;
   endfunction

   function automatic cscm_pkg::cscm_state_t mode_of(input logic [7:0] m);
      cscm_pkg::cscm_state_t s;
      s = cscm_pkg::CSCM_ST_PROGRAM;
      if (m[`CSCM_MODE_OP_BIT]) begin
         s = m[`CSCM_MODE_MIXED_BIT] ? cscm_pkg::CSCM_ST_MIXED
                                     : cscm_pkg::CSCM_ST_DATA;
      end
      return s;
   endfunction

   cscm_rx u_rx (
      .clk           (clk),
      .rst           (rst),
      .serial_in     (serial_in),
      .in_frame_sync (in_frame_sync),
      .word          (rx_word),
      .word_valid    (rx_valid)
   );

   // Holds two frames while the decoder waits on a pending forward
   cscm_buf2 u_buf (
      .clk       (clk),
      .rst       (rst),
      .in_valid  (rx_valid),
      .in_ready  (rx_ready),
      .in_data   (rx_word),
      .out_valid (head_valid),
      .out_ready (head_take),
      .out_data  (head)
   );

   // Reset sequencing, shared by the pin and the mode register bit
   assign busy = (rst_cnt_r != 3'h0);

   always_ff @(posedge clk) begin
      if (rst) begin
         rst_cnt_r <= `CSCM_RST_CYCLES;
      end else if (swrst_req) begin
         rst_cnt_r <= `CSCM_RST_CYCLES;
      end else if (busy) begin
         rst_cnt_r <= rst_cnt_r - 3'h1;
      end
   end

   // Frame classification
   // Held frames wait one more edge until the state has left reset
   assign head_take = head_valid && !busy && !fwd_v_r
                   && (st_r != cscm_pkg::CSCM_ST_RESET);
   assign is_dac    = (st_r == cscm_pkg::CSCM_ST_DATA)
                   || (st_r == cscm_pkg::CSCM_ST_MIXED && !head.ctl_flag);
   assign is_ctl    = head.ctl_flag
                   && (st_r == cscm_pkg::CSCM_ST_PROGRAM
                       || st_r == cscm_pkg::CSCM_ST_MIXED);
   assign mine      = (head.dev_addr == `CSCM_DEV_ZERO);
   assign ctl_wr    = head_take && is_ctl && mine && !head.rd_flag;
   assign ctl_rd    = head_take && is_ctl && mine && head.rd_flag;
   assign swrst_req = ctl_wr && (head.reg_addr == `CSCM_ADDR_MODE)
                   && head.reg_data[`CSCM_MODE_SWRST_BIT];
   assign echo      = regs_r.clock_divider_control[`CSCM_CLK_ECHO_BIT];

   // Register bank; reset bit never stored
   always_ff @(posedge clk) begin
      if (rst || busy || swrst_req) begin
         regs_r <= {5{`CSCM_REG_RESET}};
      end else if (ctl_wr) begin
         case (head.reg_addr)
            `CSCM_ADDR_MODE: begin
               regs_r.mode_control <= head.reg_data;
            end
            `CSCM_ADDR_CLKDIV: begin
               regs_r.clock_divider_control <= head.reg_data;
            end
            `CSCM_ADDR_POWER: begin
               regs_r.power_control <= head.reg_data;
            end
            `CSCM_ADDR_GAIN: begin
               regs_r.gain_control <= head.reg_data;
            end
            `CSCM_ADDR_DACTIME: begin
               regs_r.dac_timing_control <= head.reg_data;
            end
            default: begin
            end
         endcase
      end
   end

   // Operating state follows the mode register
   always_comb begin
      st_nxt = mode_of(regs_r.mode_control);
      if (busy) begin
         st_nxt = cscm_pkg::CSCM_ST_RESET;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= cscm_pkg::CSCM_ST_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // Sample rate switches after first divider write
   always_ff @(posedge clk) begin
      if (rst || busy) begin
         fast_r <= 1'b0;
      end else if (ctl_wr && head.reg_addr == `CSCM_ADDR_CLKDIV) begin
         fast_r <= 1'b1;
      end
   end

   // Forward slot: decremented words, read replies, echoed writes
   always_ff @(posedge clk) begin
      if (rst || busy) begin
         fwd_v_r <= 1'b0;
         fwd_r   <= '0;
      end else if (head_take && is_ctl && !mine) begin
         fwd_v_r        <= 1'b1;
         fwd_r          <= head;
         fwd_r.dev_addr <= head.dev_addr - `CSCM_DEV_ONE;
      end else if (ctl_rd) begin
         fwd_v_r        <= 1'b1;
         fwd_r          <= head;
         fwd_r.reg_data <= reg_read(regs_r, head.reg_addr);
      end else if (ctl_wr && echo && !swrst_req) begin
         fwd_v_r <= 1'b1;
         fwd_r   <= head;
      end else if (sample_evt) begin
         fwd_v_r <= 1'b0;
      end
   end

   // DAC frames counted against the cascade count
   assign dac_word = (st_r == cscm_pkg::CSCM_ST_MIXED) ? {head[14:0], 1'b0}
                                                       : head;
   always_ff @(posedge clk) begin
      if (rst || busy) begin
         frm_cnt_r <= `CSCM_DEV_ZERO;
         dac_data  <= 16'h0000;
         dac_load  <= 1'b0;
      end else begin
         dac_load <= 1'b0;
         if (head_take && is_dac) begin
            if (frm_cnt_r == regs_r.mode_control[`CSCM_MODE_CNT_HI:`CSCM_MODE_CNT_LO]) begin
               frm_cnt_r <= `CSCM_DEV_ZERO;
               dac_data  <= dac_word;
               dac_load  <= 1'b1;
            end else begin
               frm_cnt_r <= frm_cnt_r + `CSCM_DEV_ONE;
            end
         end
      end
   end

   // Sample timer; idles at zero until the serial port is enabled
   assign sample_evt = (tmr_r == 11'h000) && serial_port_enable && !busy;
   always_ff @(posedge clk) begin
      if (rst || busy) begin
         tmr_r <= 11'h000;
      end else if (sample_evt) begin
         tmr_r <= fast_r ? `CSCM_FAST_RELOAD : `CSCM_SLOW_RELOAD;
      end else if (tmr_r != 11'h000) begin
         tmr_r <= tmr_r - 11'h001;
      end
   end

   // Outgoing word: pending forward wins over the ADC sample
   always_comb begin
      tx_word = adc_sample;
      if (fwd_v_r) begin
         tx_word = fwd_r;
      end else if (st_r == cscm_pkg::CSCM_ST_MIXED) begin
         tx_word = {1'b0, adc_sample[14:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (rst || busy) begin
         out_frame_sync <= 1'b0;
         serial_out     <= 1'b0;
         tx_sh_r        <= 16'h0000;
         tx_cnt_r       <= `CSCM_CNT_IDLE;
      end else begin
         out_frame_sync <= sample_evt;
         if (sample_evt) begin
            tx_sh_r  <= tx_word;
            tx_cnt_r <= `CSCM_WORD_BITS;
         end else if (tx_cnt_r != `CSCM_CNT_IDLE) begin
            serial_out <= tx_sh_r[15];
            tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
            tx_cnt_r   <= tx_cnt_r - `CSCM_CNT_LAST;
         end else begin
            serial_out <= 1'b0;
         end
      end
   end

   // Overrun: frame arrived with both buffer slots taken
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_overrun <= 1'b0;
      end else begin
         rx_overrun <= rx_valid && !rx_ready;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_regs <= {5{`CSCM_REG_RESET}};
         op_state  <= cscm_pkg::CSCM_ST_RESET;
         in_reset  <= 1'b1;
      end else begin
         ctrl_regs <= regs_r;
         op_state  <= st_r;
         in_reset  <= busy;
      end
   end

endmodule

// [test/cscm_assertions.sv]
`timescale 1ns/100ps

module cscm_assertions (
   input wire logic                  clk,
   input wire logic                  rst,
   input wire logic                  serial_port_enable,
   input wire logic                  out_frame_sync,
   input wire cscm_pkg::cscm_regs_t  ctrl_regs,
   input wire cscm_pkg::cscm_state_t op_state,
   input wire logic                  in_reset,
   input wire logic                  dac_load,
   input wire logic                  rx_overrun
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_sync_spacing: assert property (out_frame_sync |=> !out_frame_sync [*8])
      else $error("output frame sync pulses too close");
   a_sync_enable: assert property (out_frame_sync |-> $past(serial_port_enable))
      else $error("output frame sync without serial enable");
   // Own disable: this one must be live while reset is held
   a_reset_clear: assert property (disable iff (1'b0)
      rst ##1 rst |=> ctrl_regs == '0 && in_reset)
      else $error("registers not cleared during reset");
   a_swrst_len: assert property ($rose(in_reset) |-> in_reset [*4] ##[1:3] !in_reset)
      else $error("internal reset length wrong");
   a_reset_ends: assert property ($fell(in_reset) |->
      ctrl_regs == '0 ##[0:2] op_state == cscm_pkg::CSCM_ST_PROGRAM)
      else $error("reset did not end in program mode");
   a_mixed_state: assert property ($changed(op_state) &&
      op_state == cscm_pkg::CSCM_ST_MIXED |-> ##[0:2] ctrl_regs.mode_control[1:0] == 2'b11)
      else $error("mixed state without mixed bits");
   a_data_state: assert property ($changed(op_state) &&
      op_state == cscm_pkg::CSCM_ST_DATA |-> ##[0:2] ctrl_regs.mode_control[1:0] == 2'b01)
      else $error("data state without data bits");
   a_data_frozen: assert property (op_state == cscm_pkg::CSCM_ST_DATA &&
      $past(op_state, 3) == cscm_pkg::CSCM_ST_DATA |-> $stable(ctrl_regs))
      else $error("registers changed in plain data mode");
   a_prog_no_dac: assert property (op_state == cscm_pkg::CSCM_ST_PROGRAM &&
      $past(op_state) == cscm_pkg::CSCM_ST_PROGRAM |-> !dac_load)
      else $error("dac load in program mode");

   c_mixed_dac: cover property (op_state == cscm_pkg::CSCM_ST_MIXED && dac_load);
   c_data_dac: cover property (op_state == cscm_pkg::CSCM_ST_DATA && dac_load);
   c_soft_reset: cover property ($rose(in_reset));
   c_overrun: cover property (rx_overrun);
endmodule

bind cscm_top cscm_assertions u_chk (
   .clk(clk),
   .rst(rst),
   .serial_port_enable(serial_port_enable),
   .out_frame_sync(out_frame_sync),
   .ctrl_regs(ctrl_regs),
   .op_state(op_state),
   .in_reset(in_reset),
   .dac_load(dac_load),
   .rx_overrun(rx_overrun)
);

// [test/cscm_host.sv]
`timescale 1ns/100ps

module cscm_host (
   input  wire logic clk,
   input  wire logic serial_out,
   input  wire logic out_frame_sync,
   output logic      serial_in,
   output logic      in_frame_sync
);
   logic [15:0] shift;
   logic [15:0] rx_word = 16'h0000;
   int          bits_left = 0;

   initial begin
      serial_in = 1'b0;
      in_frame_sync = 1'b0;
   end

   task automatic send_frame(input logic [15:0] w);
      @(posedge clk);
      #1 in_frame_sync = 1'b1;
      for (int i = 15; i >= 0; i--) begin
         @(posedge clk);
         #1 in_frame_sync = 1'b0;
         serial_in = w[i];
      end
      @(posedge clk);
      // Idle line shows the inverse so a stale bit cannot pass
      #1 serial_in = ~serial_in;
   endtask

   // Raw capture only; the bench decides which words mean anything
   always @(posedge clk) begin
      if (bits_left != 0) begin
         shift = {shift[14:0], serial_out};
         bits_left = bits_left - 1;
         if (bits_left == 0)
            rx_word = shift;
      end else if (out_frame_sync === 1'b1) begin
         bits_left = 16;
      end
   end
endmodule

// [test/codec_serial_control_modes_tb.sv]
`timescale 1ns/100ps

module codec_serial_control_modes_tb;
   logic                  clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  serial_port_enable = 1'b0;
   logic [15:0]           adc_sample = 16'h0000;
   logic                  serial_in;
   logic                  in_frame_sync;
   logic                  serial_out;
   logic                  out_frame_sync;
   cscm_pkg::cscm_regs_t  ctrl_regs;
   cscm_pkg::cscm_state_t op_state;
   logic                  in_reset;
   logic [15:0]           dac_data;
   logic                  dac_load;
   logic                  rx_overrun;
   int                    err_count = 0;
   int                    total_checks = 0;
   int                    cycles = 0;
   int                    ovr_seen = 0;
   int                    load_seen = 0;

   cscm_top uut (.clk(clk), .rst(rst), .serial_port_enable(serial_port_enable),
      .serial_in(serial_in), .in_frame_sync(in_frame_sync), .adc_sample(adc_sample),
      .serial_out(serial_out), .out_frame_sync(out_frame_sync), .ctrl_regs(ctrl_regs),
      .op_state(op_state), .in_reset(in_reset), .dac_data(dac_data),
      .dac_load(dac_load), .rx_overrun(rx_overrun));

   cscm_host u_host (.clk(clk), .serial_out(serial_out), .out_frame_sync(out_frame_sync),
      .serial_in(serial_in), .in_frame_sync(in_frame_sync));

   always #2.5 clk = ~clk;

   task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (rx_overrun === 1'b1)
         ovr_seen++;
      if (dac_load === 1'b1)
         load_seen++;
      if (cycles == 30000) begin
         err_count++;
         test_done();
      end
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic ctl(input logic rd, input logic [2:0] ra, input logic [7:0] d);
      u_host.send_frame({1'b1, rd, 3'h0, ra, d});
      tick(4);
   endtask

   task automatic wait_sync(input int lim, output int n);
      n = 0;
      do begin
         tick(1);
         n++;
      end while (out_frame_sync !== 1'b1 && n < lim);
   endtask

   task automatic next_word(input int lim);
      int n;
      wait_sync(lim, n);
      tick(17);
   endtask

   task automatic dac_frame(input logic [15:0] w, input logic [15:0] exp);
      u_host.send_frame(w);
      tick(4);
      chk("dac data", exp, dac_data);
   endtask

   task automatic test_reset();
      int n;
      tick(4);
      rst = 1'b0;
      tick(8);
      chk("reset regs", '0, ctrl_regs);
      chk("reset state", cscm_pkg::CSCM_ST_PROGRAM, op_state);
      serial_port_enable = 1'b1;
      wait_sync(2100, n);
      chk("first sync", 1'b1, out_frame_sync);
      wait_sync(2100, n);
      chk("slow period", 2048, n);
   endtask

   task automatic test_config();
      int n;
      ctl(0, 3'h1, 8'h03);
      ctl(0, 3'h2, 8'h79);
      ctl(0, 3'h3, 8'ha5);
      ctl(0, 3'h4, 8'h3f);
      ctl(0, 3'h5, 8'hff);
      dac_frame(16'h0355, 16'h0000);
      ctl(0, 3'h0, 8'h00);
      chk("all regs", 40'h3f_a5_79_03_00, ctrl_regs);
      wait_sync(2100, n);
      wait_sync(300, n);
      chk("fast period", 256, n);
   endtask

   task automatic test_forward();
      int n;
      // Forward holds decode, so the trailing frames pile into the buffer
      wait_sync(300, n);
      u_host.send_frame({1'b1, 1'b0, 3'h2, 3'h3, 8'h11});
      u_host.send_frame({5'h10, 3'h3, 8'h21});
      u_host.send_frame({5'h10, 3'h3, 8'h22});
      u_host.send_frame({5'h10, 3'h3, 8'h23});
      next_word(300);
      chk("forward word", 16'h8b11, u_host.rx_word);
      chk("overrun", 1, ovr_seen);
      tick(4);
      chk("drained gain", 8'h22, ctrl_regs.gain_control);
      ctl(1, 3'h3, 8'h00);
      next_word(300);
      chk("read data", 8'h22, u_host.rx_word[7:0]);
   endtask

   task automatic test_mixed();
      ctl(0, 3'h0, 8'h80);
      tick(8);
      chk("soft reset regs", '0, ctrl_regs);
      chk("soft reset state", cscm_pkg::CSCM_ST_PROGRAM, op_state);
      ctl(0, 3'h0, 8'h03);
      chk("mixed state", cscm_pkg::CSCM_ST_MIXED, op_state);
      dac_frame(16'h1234, 16'h2468);
      ctl(0, 3'h3, 8'h5a);
      chk("mixed control", 8'h5a, ctrl_regs.gain_control);
      adc_sample = 16'hffff;
      next_word(2100);
      chk("adc flag", 16'h7fff, u_host.rx_word);
      // Echo takes effect from the write after the one that sets it
      ctl(0, 3'h1, 8'h83);
      ctl(0, 3'h3, 8'h66);
      chk("echo gain", 8'h66, ctrl_regs.gain_control);
      next_word(2100);
      chk("echo word", 16'h8366, u_host.rx_word);
   endtask

   task automatic test_data();
      rst = 1'b1;
      tick(4);
      rst = 1'b0;
      tick(8);
      ctl(0, 3'h0, 8'h11);
      chk("data state", cscm_pkg::CSCM_ST_DATA, op_state);
      dac_frame(16'h8abc, 16'h0000);
      dac_frame(16'h835a, 16'h835a);
      chk("frozen regs", 40'h11, ctrl_regs);
      chk("dac loads", 2, load_seen);
   endtask

   initial begin
      test_reset();
      test_config();
      test_forward();
      test_mixed();
      test_data();
      test_done();
   end
endmodule
